// ===== pkg/spi_status_pkg.sv
// constants and carrier types for the serial port status and mode block
package spi_status_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_FIFO_STATUS = 8'h14;
  localparam logic [7:0] OFF_RO_CONTROL  = 8'h24;
  localparam logic [7:0] OFF_RO_MATCH    = 8'h28;
  localparam logic [7:0] OFF_RO_CAPTURE  = 8'h2C;
  localparam logic [7:0] OFF_CLK_CONTROL = 8'h3C;
  localparam logic [7:0] OFF_THREE_WIRE  = 8'h54;
  // fifo_status field positions
  localparam int B_ROR  = 20;
  localparam int B_RFL  = 15;
  localparam int B_RNE  = 14;
  localparam int B_RFS  = 13;
  localparam int B_TUR  = 12;
  localparam int B_TFL  = 7;
  localparam int B_TNF  = 6;
  localparam int B_TFS  = 5;
  localparam int B_RX_TIMEOUT_FLAG = 3;
  localparam int B_CSS  = 1;
  localparam int B_BSY  = 0;
  // receive_only_control field positions
  localparam int B_MASK_LAST = 4;
  localparam int B_CNT_CLEAR = 3;
  localparam int B_CNT_LOAD  = 2;
  localparam int B_CNT_EN    = 1;
  localparam int B_RX_ONLY   = 0;
  // core_clock_control field positions
  localparam int B_DI_SEL  = 9;
  localparam int B_CLK_EN  = 8;
  localparam int B_CLK_SEL = 7;
  localparam int B_DIV     = 0;
  localparam int DIV_W     = 7;
  // three_wire_control field positions
  localparam int B_LIVE_WIDTH = 2;
  localparam int B_PIN_DIR    = 1;
  localparam int B_TRI_EN     = 0;
  // fifo geometry and reset values
  localparam int             LVL_W      = 5;
  localparam logic [4:0]     FIFO_DEPTH = 5'h10;
  localparam logic [31:0]    ZERO32     = 32'h0000_0000;
  localparam logic [DIV_W-1:0] DIV_ONE  = 7'h01;
  localparam logic [4:0]     LVL_ONE    = 5'h01;

  // receive-only counter states, one-hot
  typedef enum logic [2:0] {
    RO_IDLE = 3'b001,
    RO_RUN  = 3'b010,
    RO_DONE = 3'b100
  } ro_state_t;

  // fifo levels and thresholds from the datapath
  typedef struct packed {
    logic [LVL_W-1:0] rx_count;
    logic [LVL_W-1:0] tx_count;
    logic [3:0]       rx_threshold;
    logic [3:0]       tx_threshold;
  } fifo_levels_t;

  // one-cycle events and live levels from the core
  typedef struct packed {
    logic tx_underrun;
    logic rx_overrun;
    logic rx_timeout;
    logic sclk_cycle;
    logic last_sample;
    logic frame_active;
    logic slave_sync_pending;
  } core_events_t;
endpackage : spi_status_pkg

// ===== rtl/spi_status_ctrl.sv
// status flags, receive-only counter, core clock divider and three-wire pin control
`timescale 1ns/1ps
// Notes on behaviour
// - rx service request high while enabled and rx level above threshold.
// - tx underrun sets on empty-fifo read; write one clears; mask gates interrupt.
// - tx fill level reports tx fifo entries; zero is empty or full.
// - tx not full low only when tx fifo is full.
// - tx service request high while enabled and level at most threshold plus one.
// - rx timeout flag sets on timeout, pending until write one.
// - slave sync pending shows slave-signal synchronisation in progress.
// - frame active high while transferring, low when idle or disabled.
// - last-sample mask hides last-sample indication in receive-only mode.
// - counter clear bit zeroes counter, self-clears once port enabled.
// - counter load bit loads match value, self-clears once port enabled.
// - counter enable makes counter count serial clocks in receive-only mode.
// - receive-only bit: zero full duplex, one receive without transmitting.
// - master receive-only stops serial clock when counter equals match value.
// - writing one to capture snapshots counter when enabled; reads return snapshot.
// - data input select picks dedicated input or bidirectional pin.
// - internal clock enable gates the core clock.
// - clock select: zero divided clock, one system clock.
// - seven-bit divider sets system clock division ratio.
// - live width change allows frame width change without re-enable.
// - pin direction in three-wire mode: one input, zero output.
// - three-wire enable selects half-duplex on bidirectional pin.
// - rx overrun sets on write to full rx fifo; write one clears.
// - rx not empty high whenever rx fifo holds an entry.
module spi_status_ctrl
  import spi_status_pkg::*;
(
  // apb slave
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  // core side
  input  wire logic         port_enable,
  input  wire logic         master_mode,
  input  wire logic         tx_underrun_mask,
  input  wire fifo_levels_t levels,
  input  wire core_events_t events,
  input  wire logic         tx_serial_bit,
  // core outputs
  output logic              rx_service_request,
  output logic              tx_service_request,
  output logic              tx_underrun_irq,
  output logic              rx_overrun_irq,
  output logic              rx_timeout_irq,
  output logic              last_sample_out,
  output logic              rx_only_stop,
  output logic              core_tick,
  output logic              live_width_change,
  output logic              rx_serial_bit,
  // pins
  input  wire logic         serial_input_pin,
  output logic              serial_output_pin,
  input  wire logic         bidir_in,
  output logic              bidir_out,
  output logic              bidir_oe_n
);

  typedef struct packed {
    logic [4:0]       ro_ctrl;
    logic [31:0]      match;
    logic [31:0]      snapshot;
    logic [31:0]      counter;
    logic [9:0]       clk_ctrl;
    logic [2:0]       tri_ctrl;
    logic             rx_overrun_flag;
    logic             tx_underrun_flag;
    logic             rx_timeout_flag;
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    logic             rx_bit;
    logic [31:0]      rdata;
    ro_state_t        ro_state;
  } state_t;

  state_t s;
  state_t next_s;

  logic        wr_access;
  logic        rd_setup;
  logic        hit;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [4:0]  rfl_full;
  logic [4:0]  tfs_limit;
  logic        rx_only;
  logic        cnt_en;
  logic        at_match;

  // bus decode
  assign wr_access = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign hit = (paddr == OFF_FIFO_STATUS) | (paddr == OFF_RO_CONTROL) |
               (paddr == OFF_RO_MATCH) | (paddr == OFF_RO_CAPTURE) |
               (paddr == OFF_CLK_CONTROL) | (paddr == OFF_THREE_WIRE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = s.rdata;

  assign rx_only   = s.ro_ctrl[B_RX_ONLY];
  assign cnt_en    = s.ro_ctrl[B_CNT_EN];
  assign at_match  = (s.counter == s.match);
  assign rfl_full  = levels.rx_count - LVL_ONE;
  assign tfs_limit = {1'b0, levels.tx_threshold} + LVL_ONE;

  // status flags from live fifo levels, sticky flags and core event levels
  always_comb begin
    status_word = ZERO32;
    status_word[B_ROR] = s.rx_overrun_flag;
    status_word[B_RFL +: 4] = rfl_full[3:0];
    status_word[B_RNE] = (levels.rx_count != 5'h00);
    status_word[B_RFS] = port_enable & (levels.rx_count > {1'b0, levels.rx_threshold});
    status_word[B_TUR] = s.tx_underrun_flag;
    status_word[B_TFL +: 4] = levels.tx_count[3:0];
    status_word[B_TNF] = (levels.tx_count != FIFO_DEPTH);
    status_word[B_TFS] = port_enable & (levels.tx_count <= tfs_limit);
    status_word[B_RX_TIMEOUT_FLAG] = s.rx_timeout_flag;
    status_word[B_CSS] = port_enable & events.slave_sync_pending;
    status_word[B_BSY] = port_enable & events.frame_active;
  end

  // read mux
  always_comb begin
    rd_word = ZERO32;
    case (paddr)
      OFF_FIFO_STATUS: rd_word = status_word;
      OFF_RO_CONTROL:  rd_word[4:0] = s.ro_ctrl;
      OFF_RO_MATCH:    rd_word = s.match;
      OFF_RO_CAPTURE:  rd_word = s.snapshot;
      OFF_CLK_CONTROL: rd_word[9:0] = s.clk_ctrl;
      OFF_THREE_WIRE:  rd_word[2:0] = s.tri_ctrl;
      default:         rd_word = ZERO32;
    endcase
  end

  // next state
  always_comb begin
    next_s = s;
    next_s.rdata = rd_setup ? rd_word : s.rdata;
    // register writes
    if (wr_access) begin
      case (paddr)
        OFF_RO_CONTROL:  next_s.ro_ctrl = pwdata[4:0];
        OFF_RO_MATCH:    next_s.match = pwdata;
        OFF_CLK_CONTROL: next_s.clk_ctrl = pwdata[9:0];
        OFF_THREE_WIRE:  next_s.tri_ctrl = pwdata[2:0];
        default:         next_s.tri_ctrl = s.tri_ctrl;
      endcase
    end
    next_s.tx_underrun_flag = (s.tx_underrun_flag & ~(wr_access & (paddr == OFF_FIFO_STATUS) & pwdata[B_TUR]))
                 | events.tx_underrun;
    next_s.rx_overrun_flag = (s.rx_overrun_flag & ~(wr_access & (paddr == OFF_FIFO_STATUS) & pwdata[B_ROR]))
                 | events.rx_overrun;
    next_s.rx_timeout_flag = (s.rx_timeout_flag & ~(wr_access & (paddr == OFF_FIFO_STATUS) & pwdata[B_RX_TIMEOUT_FLAG]))
                  | events.rx_timeout;
    // count serial clocks in receive-only run
    if (s.ro_state == RO_RUN && events.sclk_cycle && !at_match)
      next_s.counter = s.counter + 32'h0000_0001;
    if (s.ro_ctrl[B_CNT_CLEAR] && port_enable) begin
      next_s.counter = ZERO32;
      next_s.ro_ctrl[B_CNT_CLEAR] = 1'b0;
    end
    // load counter from match, self-clear when enabled
    else if (s.ro_ctrl[B_CNT_LOAD] && port_enable) begin
      next_s.counter = s.match;
      next_s.ro_ctrl[B_CNT_LOAD] = 1'b0;
    end
    // capture on write one while enabled
    if (wr_access && paddr == OFF_RO_CAPTURE && pwdata[0] && port_enable)
      next_s.snapshot = s.counter;
    case (s.ro_state)
      RO_IDLE: begin
        if (port_enable && rx_only && cnt_en && events.frame_active)
          next_s.ro_state = RO_RUN;
      end
      RO_RUN: begin
        if (!port_enable || !rx_only || !cnt_en)
          next_s.ro_state = RO_IDLE;
        else if (master_mode && at_match)
          next_s.ro_state = RO_DONE;
      end
      RO_DONE: begin
        if (!port_enable || !rx_only || s.ro_ctrl[B_CNT_CLEAR] || s.ro_ctrl[B_CNT_LOAD])
          next_s.ro_state = RO_IDLE;
      end
      default: next_s.ro_state = RO_IDLE;
    endcase
    if (!s.clk_ctrl[B_CLK_EN]) begin
      next_s.tick = 1'b0;
      next_s.div_cnt = '0;
    end else if (s.clk_ctrl[B_CLK_SEL] || s.clk_ctrl[B_DIV +: DIV_W] <= DIV_ONE) begin
      // divider of zero or one passes through
      next_s.tick = 1'b1;
      next_s.div_cnt = '0;
    end else if (s.div_cnt >= s.clk_ctrl[B_DIV +: DIV_W] - DIV_ONE) begin
      next_s.tick = 1'b1;
      next_s.div_cnt = '0;
    end else begin
      next_s.tick = 1'b0;
      next_s.div_cnt = s.div_cnt + DIV_ONE;
    end
    next_s.rx_bit = s.clk_ctrl[B_DI_SEL] ? bidir_in : serial_input_pin;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{ro_state: RO_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // core-facing outputs
  assign rx_service_request = status_word[B_RFS];
  assign tx_service_request = status_word[B_TFS];
  assign tx_underrun_irq    = s.tx_underrun_flag & ~tx_underrun_mask;
  assign rx_overrun_irq     = s.rx_overrun_flag;
  assign rx_timeout_irq     = s.rx_timeout_flag;
  // mask last sample in receive-only mode
  assign last_sample_out    = events.last_sample & ~(rx_only & s.ro_ctrl[B_MASK_LAST]);
  assign rx_only_stop       = (s.ro_state == RO_DONE);
  assign core_tick          = s.tick;
  // live width change to control logic
  assign live_width_change  = s.tri_ctrl[B_LIVE_WIDTH];
  assign rx_serial_bit      = s.rx_bit;

  // pins; serial outputs forced low and bidir pin released in receive-only mode
  assign serial_output_pin = tx_serial_bit & ~rx_only;
  assign bidir_out         = tx_serial_bit & ~rx_only;
  assign bidir_oe_n = ~(s.tri_ctrl[B_TRI_EN] & ~s.tri_ctrl[B_PIN_DIR] & ~rx_only);

  // checks
  rfs_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_service_request == (port_enable && levels.rx_count > {1'b0, levels.rx_threshold}))
    else $error("rx service request wrong");
  tur_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    events.tx_underrun |=> s.tx_underrun_flag ##0 (tx_underrun_irq == !tx_underrun_mask))
    else $error("underrun not set");
  tnf_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (levels.tx_count == FIFO_DEPTH) |-> !status_word[B_TNF])
    else $error("tx not full while full");
  tfs_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (port_enable && levels.tx_count <= tfs_limit) |-> tx_service_request)
    else $error("tx service request missing");
  rx_timeout_flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.rx_timeout_flag && !(wr_access && paddr == OFF_FIFO_STATUS)) |=> s.rx_timeout_flag)
    else $error("timeout flag lost");
  cnt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ro_ctrl[B_CNT_CLEAR] && port_enable) |=>
      (s.counter == ZERO32 && !s.ro_ctrl[B_CNT_CLEAR]))
    else $error("counter clear failed");
  cnt_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ro_ctrl[B_CNT_LOAD] && !s.ro_ctrl[B_CNT_CLEAR] && port_enable) |=>
      (s.counter == $past(s.match)))
    else $error("counter load failed");
  ro_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ro_state == RO_RUN && port_enable && rx_only && cnt_en && master_mode && at_match)
      |=> rx_only_stop)
    else $error("receive-only stop missed");
  capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == OFF_RO_CAPTURE && pwdata[0] && port_enable) |=>
      (s.snapshot == $past(s.counter)))
    else $error("snapshot wrong");
  div_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.clk_ctrl[B_CLK_EN] && s.clk_ctrl[B_DIV +: DIV_W] <= DIV_ONE) [*2] |=> core_tick)
    else $error("pass-through tick missing");
  pin_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.tri_ctrl[B_TRI_EN] && s.tri_ctrl[B_PIN_DIR]) |-> bidir_oe_n)
    else $error("bidir pin driven as input");

endmodule : spi_status_ctrl

// ===== bench/spi_far_device.sv
// far-side serial device model driving the receive pins
`timescale 1ns/1ps
module spi_far_device (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins seen from the far side
  input  wire logic bidir_oe_n,
  output logic      serial_input_pin,
  output logic      far_out
);
  logic [7:0] pattern;
  // new bits every cycle so that a stale level shows up wherever two successive bits differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern <= 8'hA5;
    end else begin
      pattern <= {pattern[6:0], pattern[7] ^ pattern[5] ^ pattern[4] ^ pattern[3]};
    end
  end
  // drive pattern bit 3 while the block has released the shared line, its inverse while the block drives it
  assign serial_input_pin = pattern[0];
  assign far_out          = bidir_oe_n ? pattern[3] : ~pattern[3];
endmodule : spi_far_device

// ===== bench/test_spi_status_ctrl.sv
// self-checking bench for the serial port status and mode block
`timescale 1ns/1ps
module test_spi_status_ctrl;
  import spi_status_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, r;
  logic         port_enable, master_mode, tx_underrun_mask, tx_serial_bit;
  fifo_levels_t levels;
  core_events_t ev;
  logic         rx_service_request, tx_service_request, tx_underrun_irq, rx_overrun_irq;
  logic         rx_timeout_irq, last_sample_out, rx_only_stop, core_tick, live_width_change;
  logic         rx_serial_bit, serial_input_pin, serial_output_pin, bidir_out, bidir_oe_n;
  logic         far_out, bidir_wire, sampled;
  logic [2:0]   irqv;
  int           mismatches, comparisons, cycles, n;
  logic [7:0]   regs [5] = '{OFF_RO_CONTROL, OFF_RO_MATCH, OFF_RO_CAPTURE, OFF_CLK_CONTROL,
                             OFF_THREE_WIRE};
  fifo_levels_t lv [3] = '{'{5'h05, 5'h03, 4'h4, 4'h2}, '{5'h10, 5'h02, 4'h4, 4'h2},
                           '{5'h04, 5'h10, 4'h4, 4'h2}};
  logic [31:0]  sx [3] = '{32'h0002_61E3, 32'h0007_C140, 32'h0001_C000};
  int           fb [3] = '{B_TUR, B_ROR, B_RX_TIMEOUT_FLAG};
  logic [9:0]   dv [5] = '{10'h104, 10'h184, 10'h101, 10'h100, 10'h004};
  int           dx [5] = '{10, 40, 40, 40, 0};

  // wire level of the shared data line
  assign bidir_wire = bidir_oe_n ? far_out : bidir_out;
  assign irqv       = {tx_underrun_irq, rx_overrun_irq, rx_timeout_irq};

  spi_status_ctrl i_spi_status_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .port_enable, .master_mode, .tx_underrun_mask, .levels, .events(ev), .tx_serial_bit,
    .rx_service_request, .tx_service_request, .tx_underrun_irq, .rx_overrun_irq,
    .rx_timeout_irq, .last_sample_out, .rx_only_stop, .core_tick, .live_width_change,
    .rx_serial_bit, .serial_input_pin, .serial_output_pin, .bidir_in(bidir_wire),
    .bidir_out, .bidir_oe_n
  );
  spi_far_device i_spi_far_device (.pclk, .presetn, .bidir_oe_n, .serial_input_pin, .far_out);

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, ZERO32);
    chk(r, exp);
  endtask : rd

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
    @(posedge pclk);
  endtask : pulse

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {port_enable, master_mode, tx_underrun_mask, tx_serial_bit} = '0;
    levels = '0;
    ev = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values of the mode registers, field widths of match, clock control and three-wire
    foreach (regs[i]) rd(regs[i], ZERO32);
    apb(1'b1, OFF_RO_MATCH, 32'hFFFF_FFFF);
    rd(OFF_RO_MATCH, 32'hFFFF_FFFF);
    apb(1'b1, OFF_CLK_CONTROL, 32'hFFFF_FFFF);
    rd(OFF_CLK_CONTROL, 32'h0000_03FF);
    apb(1'b1, OFF_THREE_WIRE, 32'hFFFF_FFFF);
    rd(OFF_THREE_WIRE, 32'h0000_0007);
    chk(32'(live_width_change), 32'h1);
    chk(32'(bidir_oe_n), 32'h1);
    // unmapped place refused
    apb(1'b1, 8'h30, 32'hFFFF_FFFF);
    chk(32'(e), 32'h1);
    rd(8'h30, ZERO32);
    // three-wire drive follows the shifter, released in receive-only mode
    apb(1'b1, OFF_THREE_WIRE, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      tx_serial_bit <= i[0];
      @(posedge pclk);
      chk({bidir_oe_n, bidir_wire, serial_output_pin}, {1'b0, i[0], i[0]});
    end
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_0001);
    chk({bidir_oe_n, serial_output_pin}, 2'b10);
    // last-sample masking only in receive-only mode
    ev.last_sample <= 1'b1;
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_0011);
    chk(32'(last_sample_out), ZERO32);
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_0010);
    chk(32'(last_sample_out), 32'h1);
    ev.last_sample <= 1'b0;
    apb(1'b1, OFF_THREE_WIRE, ZERO32);
    // status fields against fifo levels and enable
    for (int i = 0; i < 3; i++) begin
      levels <= lv[i];
      port_enable <= (i != 1);
      ev.frame_active <= (i == 0);
      ev.slave_sync_pending <= (i == 0);
      rd(OFF_FIFO_STATUS, sx[i]);
      chk({rx_service_request, tx_service_request}, {sx[i][B_RFS], sx[i][B_TFS]});
    end
    // sticky flags: set by event, kept by zero writes, cleared by one
    for (int i = 0; i < 3; i++) begin
      pulse(6 - i);
      apb(1'b1, OFF_FIFO_STATUS, ~(32'h1 << fb[i]));
      apb(1'b0, OFF_FIFO_STATUS, ZERO32);
      chk({r[fb[i]], irqv[2 - i]}, 2'b11);
      apb(1'b1, OFF_FIFO_STATUS, 32'h1 << fb[i]);
      apb(1'b0, OFF_FIFO_STATUS, ZERO32);
      chk({r[fb[i]], irqv[2 - i]}, 2'b00);
    end
    pulse(6);
    tx_underrun_mask <= 1'b1;
    @(posedge pclk);
    chk(32'(tx_underrun_irq), ZERO32);
    apb(1'b1, OFF_FIFO_STATUS, 32'h1 << B_TUR);
    // receive-only cycle counter, stop at match, snapshot, clear and load
    master_mode <= 1'b1;
    ev.frame_active <= 1'b1;
    apb(1'b1, OFF_RO_MATCH, 32'h0000_0003);
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_0003);
    repeat (2) pulse(3);
    chk(32'(rx_only_stop), ZERO32);
    pulse(3);
    repeat (2) @(posedge pclk);
    chk(32'(rx_only_stop), 32'h1);
    apb(1'b1, OFF_RO_CAPTURE, 32'h0000_0001);
    apb(1'b1, OFF_RO_MATCH, ZERO32);
    apb(1'b1, OFF_RO_CAPTURE, ZERO32);
    rd(OFF_RO_CAPTURE, 32'h0000_0003);
    apb(1'b1, OFF_RO_MATCH, 32'h0000_0003);
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_000B);
    rd(OFF_RO_CONTROL, 32'h0000_0003);
    chk(32'(rx_only_stop), ZERO32);
    // counter now differs from the snapshot, so a zero write must not capture
    apb(1'b1, OFF_RO_CAPTURE, ZERO32);
    rd(OFF_RO_CAPTURE, 32'h0000_0003);
    apb(1'b1, OFF_RO_CAPTURE, 32'h0000_0001);
    rd(OFF_RO_CAPTURE, ZERO32);
    apb(1'b1, OFF_RO_CONTROL, 32'h0000_0007);
    rd(OFF_RO_CONTROL, 32'h0000_0003);
    apb(1'b1, OFF_RO_CAPTURE, 32'h0000_0001);
    rd(OFF_RO_CAPTURE, 32'h0000_0003);
    // core clock ticks per 40 cycles for each divider setting
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFF_CLK_CONTROL, {22'h0, dv[i]});
      n = 0;
      repeat (40) begin
        @(posedge pclk);
        n += int'(core_tick);
      end
      chk(32'(n), 32'(dx[i]));
    end
    // receive bit source select
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFF_CLK_CONTROL, 32'h0000_0180 | (32'(s) << B_DI_SEL));
      repeat (8) begin
        @(posedge pclk);
        sampled = s ? bidir_wire : serial_input_pin;
        #1;
        chk(32'(rx_serial_bit), 32'(sampled));
      end
    end
    conclude();
  end
endmodule : test_spi_status_ctrl
